/* File: system_clock_source_select.sv */
// system clock source selection with apb registers
// assumes all oscillator levels and pins are synchronous to pclk
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module system_clock_source_select
  import clk_sel_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // configuration word
  input  wire logic [3:0]        fosc_cfg,
  input  wire logic              primary_sw_enable,
  // oscillator levels
  input  wire logic              primary_xtal_clk,
  input  wire logic              secondary_osc_clk,
  input  wire logic              internal_high_osc,
  input  wire logic              internal_low_osc,
  // oscillator pins
  input  wire logic              osc_pin_in,
  input  wire logic              gpio_out_data,
  input  wire logic              gpio_out_oe,
  output logic                   osc_pin_out_o,
  output logic                   osc_pin_out_oe,
  // oscillator enables
  output logic                   primary_osc_en,
  output logic                   secondary_osc_en,
  // system clock
  output logic                   sysclk,
  output logic [1:0]             sysclk_src,
  output logic                   switch_busy
);

  // ==========================================
  // decode functions
  // mode from field
  function automatic mode_t fosc_mode(input logic [3:0] f);
    case (f)
      FOSC_LP:                   fosc_mode = MODE_LP;
      FOSC_XT:                   fosc_mode = MODE_XT;
      FOSC_RC_CKO, FOSC_RC_IO:   fosc_mode = MODE_RC;
      FOSC_ECH_CKO, FOSC_ECH_IO,
      FOSC_ECM_CKO, FOSC_ECM_IO,
      FOSC_ECL_CKO, FOSC_ECL_IO: fosc_mode = MODE_EC;
      FOSC_INT_CKO, FOSC_INT_IO: fosc_mode = MODE_INT;
      default:                   fosc_mode = MODE_HS;
    endcase
  endfunction : fosc_mode

  function automatic logic fosc_clock_output_pin(input logic [3:0] f);
    fosc_clock_output_pin = (f == FOSC_RC_CKO) || (f == FOSC_ECH_CKO) || (f == FOSC_ECM_CKO)
               || (f == FOSC_ECL_CKO) || (f == FOSC_INT_CKO);
  endfunction : fosc_clock_output_pin

  function automatic logic [1:0] int_src(input logic [2:0] ifs, input logic lfs);
    int_src = (ifs == IFS_LOWEST && !lfs) ? SRC_LF : SRC_HF;
  endfunction : int_src

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == ADDR_W'(OSC_CTRL_OFS)) || (a == ADDR_W'(OSC_CTRL2_OFS))
           || (a == ADDR_W'(OSC_TUNE_OFS)) || (a == ADDR_W'(TMR1_CTRL_OFS))
           || (a == ADDR_W'(CLK_STAT_OFS));
  endfunction : reg_hit

  // ==========================================
  // state
  logic [1:0] sel_reg;
  logic [2:0] ifs_reg;
  logic       shdn_reg;
  logic       lfsrc_reg;
  logic       t1osc_reg;
  mode_t      mode;
  logic       clock_output_pin_mode;
  logic       wr_en;
  logic       rd_setup;
  logic [1:0] req_src;
  logic       pri_lvl;
  logic       int_lvl;
  logic       hf_div;
  logic       pri_d;
  logic       div_half;
  logic       div_clk;

  assign mode        = fosc_mode(fosc_cfg);
  assign clock_output_pin_mode = fosc_clock_output_pin(fosc_cfg) && (mode == MODE_RC || mode == MODE_EC || mode == MODE_INT);
  assign wr_en       = ce && psel && penable && pwrite;
  assign rd_setup    = ce && psel && !penable && !pwrite;
  assign pready      = ce;
  assign pslverr     = psel && penable && !reg_hit(paddr);

  // ==========================================
  // register writes
  // reset to primary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= SEL_RST;
      ifs_reg <= IFS_RST;
    end else if (wr_en && paddr == ADDR_W'(OSC_CTRL_OFS)) begin
      sel_reg <= pwdata[SEL_LSB +: 2];
      ifs_reg <= pwdata[IFS_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shdn_reg <= SHDN_RST;
    end else if (wr_en && paddr == ADDR_W'(OSC_CTRL2_OFS)) begin
      shdn_reg <= pwdata[SHDN_B];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsrc_reg <= LFSRC_RST;
    end else if (wr_en && paddr == ADDR_W'(OSC_TUNE_OFS)) begin
      lfsrc_reg <= pwdata[LFSRC_B];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1osc_reg <= T1OSC_RST;
    end else if (wr_en && paddr == ADDR_W'(TMR1_CTRL_OFS)) begin
      t1osc_reg <= pwdata[T1OSC_B];
    end
  end

  // ==========================================
  // read data, captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        ADDR_W'(OSC_CTRL_OFS): begin
          prdata[SEL_LSB +: 2] <= sel_reg;
          prdata[IFS_LSB +: 3] <= ifs_reg;
          prdata[PRI_RUN_B]    <= (sysclk_src == SRC_PRI) && !switch_busy;
        end
        ADDR_W'(OSC_CTRL2_OFS): prdata[SHDN_B]  <= shdn_reg;
        ADDR_W'(OSC_TUNE_OFS):  prdata[LFSRC_B] <= lfsrc_reg;
        ADDR_W'(TMR1_CTRL_OFS): prdata[T1OSC_B] <= t1osc_reg;
        ADDR_W'(CLK_STAT_OFS): begin
          prdata[1:0]       <= sysclk_src;
          prdata[ST_BUSY_B] <= switch_busy;
          prdata[ST_PEN_B]  <= primary_osc_en;
          prdata[ST_SEN_B]  <= secondary_osc_en;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // source request
  // select decode
  always_comb begin
    if (sel_reg[1]) begin
      req_src = int_src(ifs_reg, lfsrc_reg);
    end else if (sel_reg == SEL_SECONDARY) begin
      req_src = SRC_SEC;
    end else if (mode == MODE_INT) begin
      req_src = int_src(ifs_reg, lfsrc_reg);
    end else begin
      req_src = SRC_PRI;
    end
  end

  // ==========================================
  // oscillator enables
  // shutdown gating
  // primary kept on while requested or still in use, so a switch never loses it; secondary follows t1osc_reg only
  assign primary_osc_en   = !primary_sw_enable || shdn_reg
                          || (sel_reg == SEL_PRIMARY) || (sysclk_src == SRC_PRI);
  assign secondary_osc_en = t1osc_reg;

  // ==========================================
  // primary source level
  // pin one input in rc and ec modes, internal level in int mode, crystal otherwise
  assign int_lvl = (int_src(ifs_reg, lfsrc_reg) == SRC_LF) ? internal_low_osc : hf_div;
  always_comb begin
    case (mode)
      MODE_RC, MODE_EC: pri_lvl = osc_pin_in;
      MODE_INT:         pri_lvl = int_lvl;
      default:          pri_lvl = primary_xtal_clk;
    endcase
  end

  int_osc_postscaler u_post (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .hf_lvl   (internal_high_osc),
    .freq_sel (ifs_reg),
    .div_clk  (hf_div)
  );

  glitchless_clk_mux u_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .src_lvl ({internal_low_osc, hf_div, secondary_osc_clk, pri_lvl}),
    .req_src (req_src),
    .clk_out (sysclk),
    .cur_src (sysclk_src),
    .busy    (switch_busy)
  );

  // ==========================================
  // clock output pin
  // divide by four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_d    <= 1'b0;
      div_half <= 1'b0;
      div_clk  <= 1'b0;
    end else if (ce) begin
      pri_d <= pri_lvl;
      if (pri_lvl && !pri_d) begin
        div_half <= ~div_half;
        if (div_half) begin
          div_clk <= ~div_clk;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_pin_out_o  <= 1'b0;
      osc_pin_out_oe <= 1'b0;
    end else if (ce) begin
      osc_pin_out_o  <= clock_output_pin_mode ? div_clk : gpio_out_data;
      osc_pin_out_oe <= clock_output_pin_mode ? 1'b1 : gpio_out_oe;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [2:0] rise_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cnt <= 3'h0;
    end else if (ce && div_clk != $past(div_clk)) begin
      rise_cnt <= 3'h0;
    end else if (ce && pri_lvl && !pri_d) begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end

  sec_decode_a: assert property (sel_reg == SEL_SECONDARY
                                 |-> req_src == SRC_SEC)
    else $error("secondary select not honoured");
  sel_hold_a: assert property (!(wr_en && paddr == ADDR_W'(OSC_CTRL_OFS)) |=> $stable(sel_reg))
    else $error("select changed without a write");
  lf_pick_a: assert property (sel_reg[1] && ifs_reg == IFS_LOWEST && !lfsrc_reg |-> req_src == SRC_LF)
    else $error("low internal oscillator not picked");
  no_sw_ctl_a: assert property (!primary_sw_enable |-> primary_osc_en)
    else $error("primary stopped without software enable");
  sw_stop_a: assert property (primary_sw_enable && !shdn_reg && sel_reg != SEL_PRIMARY
                              && sysclk_src != SRC_PRI |-> !primary_osc_en)
    else $error("primary not stopped by shutdown bit");
  keep_pri_a: assert property (sysclk_src == SRC_PRI |-> primary_osc_en)
    else $error("selected primary was stopped");
  pin_dir_a: assert property ((clock_output_pin_mode && ce) [*3] |-> osc_pin_out_oe)
    else $error("clock output pin not driven");
  cko_div_a: assert property (rise_cnt <= 3'(CKO_DIV / 2))
    else $error("clock output slower than divide by four");
  sec_en_a: assert property (wr_en && paddr == ADDR_W'(TMR1_CTRL_OFS)
                             |=> secondary_osc_en == $past(pwdata[T1OSC_B]))
    else $error("secondary enable not from timer bit");

  to_int_c: cover property (sysclk_src == SRC_PRI ##[1:50] sysclk_src == SRC_HF);
  to_sec_c: cover property (switch_busy ##[1:50] sysclk_src == SRC_SEC);
  pri_off_c: cover property (!primary_osc_en ##1 primary_osc_en);
  cko_run_c: cover property (clock_output_pin_mode && $rose(osc_pin_out_o));

endmodule : system_clock_source_select
`default_nettype wire

/* File: clk_sel_pkg.sv */
// constants and types for system clock source selection
// assumes 32-bit apb, byte addresses, one register per aligned word
package clk_sel_pkg;

  // ==========================================
  // register map
  localparam logic [7:0] OSC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] OSC_CTRL2_OFS = 8'h04;
  localparam logic [7:0] OSC_TUNE_OFS  = 8'h08;
  localparam logic [7:0] TMR1_CTRL_OFS = 8'h0C;
  localparam logic [7:0] CLK_STAT_OFS  = 8'h10;

  // ==========================================
  // field positions
  localparam int SEL_LSB    = 0;
  localparam int PRI_RUN_B  = 3;
  localparam int IFS_LSB    = 4;
  localparam int SHDN_B     = 2;
  localparam int LFSRC_B    = 7;
  localparam int T1OSC_B    = 3;
  localparam int ST_BUSY_B  = 2;
  localparam int ST_PEN_B   = 3;
  localparam int ST_SEN_B   = 4;

  // ==========================================
  // reset values
  localparam logic [1:0] SEL_RST   = 2'h0;
  localparam logic [2:0] IFS_RST   = 3'h3;
  localparam logic       SHDN_RST  = 1'b1;
  localparam logic       LFSRC_RST = 1'b0;
  localparam logic       T1OSC_RST = 1'b0;

  // ==========================================
  // select codes and source indices
  localparam logic [1:0] SEL_PRIMARY   = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [2:0] IFS_LOWEST    = 3'h0;
  localparam logic [1:0] SRC_PRI = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_HF  = 2'h2;
  localparam logic [1:0] SRC_LF  = 2'h3;

  // ==========================================
  // primary configuration codes
  localparam logic [3:0] FOSC_LP      = 4'h0;
  localparam logic [3:0] FOSC_XT      = 4'h1;
  localparam logic [3:0] FOSC_HS      = 4'h2;
  localparam logic [3:0] FOSC_RC_CKO  = 4'h3;
  localparam logic [3:0] FOSC_RC_IO   = 4'h4;
  localparam logic [3:0] FOSC_ECH_CKO = 4'h5;
  localparam logic [3:0] FOSC_ECH_IO  = 4'h6;
  localparam logic [3:0] FOSC_ECM_CKO = 4'h7;
  localparam logic [3:0] FOSC_ECM_IO  = 4'h8;
  localparam logic [3:0] FOSC_ECL_CKO = 4'h9;
  localparam logic [3:0] FOSC_ECL_IO  = 4'hA;
  localparam logic [3:0] FOSC_INT_CKO = 4'hB;
  localparam logic [3:0] FOSC_INT_IO  = 4'hC;

  // ==========================================
  // postscaler: log2 of divide ratio per select code, 111 -> 1, 000 -> 512
  localparam logic [3:0] PS_EXP [8] = '{4'h9, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  // clock output divides the source by four
  localparam int CKO_DIV = 4;

  typedef enum {MODE_LP, MODE_XT, MODE_HS, MODE_RC, MODE_EC, MODE_INT} mode_t;
  typedef enum {SW_RUN, SW_WAIT} sw_state_t;

endpackage : clk_sel_pkg

/* File: int_osc_postscaler.sv */
// postscaler for the high-frequency internal oscillator
// assumes the oscillator level is synchronous to pclk and slower than pclk/2
`timescale 1ns/100ps
`default_nettype none
module int_osc_postscaler
  import clk_sel_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // oscillator and select
  input  wire logic       hf_lvl,
  input  wire logic [2:0] freq_sel,
  output logic            div_clk
);

  logic [3:0] exp_v;
  logic [8:0] half_v;
  logic       hf_d;
  logic [8:0] cnt_reg;

  assign exp_v  = PS_EXP[freq_sel];
  assign half_v = (exp_v == 4'h0) ? 9'h001 : 9'(10'h001 << (exp_v - 4'h1));

  // ==========================================
  // divider
  // eight step divide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_d    <= 1'b0;
      cnt_reg <= 9'h000;
      div_clk <= 1'b0;
    end else if (ce) begin
      hf_d <= hf_lvl;
      if (exp_v == 4'h0) begin
        // rise only on fresh edge
        // a ratio change inside a high phase would otherwise cut a short pulse
        if (div_clk || !hf_lvl || !hf_d) begin
          div_clk <= hf_lvl;
        end
        cnt_reg <= 9'h000;
      end else if (hf_lvl && !hf_d) begin
        if (cnt_reg >= half_v - 9'h001) begin
          cnt_reg <= 9'h000;
          div_clk <= ~div_clk;
        end else begin
          cnt_reg <= cnt_reg + 9'h001;
        end
      end
    end
  end

endmodule : int_osc_postscaler
`default_nettype wire

/* File: glitchless_clk_mux.sv */
// glitch-free four-way clock source switch
// assumes source levels are synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module glitchless_clk_mux
  import clk_sel_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // sources and request
  input  wire logic [3:0] src_lvl,
  input  wire logic [1:0] req_src,
  // result
  output logic            clk_out,
  output logic [1:0]      cur_src,
  output logic            busy
);

  sw_state_t  state_reg;
  logic [1:0] tgt_reg;

  assign busy = (state_reg == SW_WAIT);

  // ==========================================
  // switch sequence
  // park low between sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SW_RUN;
      cur_src   <= SRC_PRI;
      tgt_reg   <= SRC_PRI;
      clk_out   <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        SW_RUN: begin
          // leave only at a low phase, so no high pulse is cut short
          if (req_src != cur_src && !src_lvl[cur_src]) begin
            clk_out   <= 1'b0;
            tgt_reg   <= req_src;
            state_reg <= SW_WAIT;
          end else begin
            clk_out <= src_lvl[cur_src];
          end
        end
        SW_WAIT: begin
          clk_out <= 1'b0;
          tgt_reg <= req_src;
          if (!src_lvl[req_src]) begin
            cur_src   <= req_src;
            state_reg <= SW_RUN;
          end
        end
        default: state_reg <= SW_RUN;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  glitch_gate_a: assert property (busy |-> !clk_out)
    else $error("clock not parked low while switching");
  new_src_low_a: assert property ((busy && ce) ##1 !busy |-> $past(!src_lvl[req_src]) && cur_src == $past(req_src))
    else $error("switch committed during a high phase");

endmodule : glitchless_clk_mux
`default_nettype wire

/* File: osc_model.sv */
// oscillator sources facing the clock select block
// assumes levels are made on pclk; half periods in pclk cycles
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
  parameter int PRI_H = 3,
  parameter int SEC_H = 6,
  parameter int HF_H  = 2,
  parameter int LF_H  = 8
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // enables from the block
  input  wire logic pri_en,
  input  wire logic sec_en,
  // oscillator levels
  output logic      pri,
  output logic      sec,
  output logic      hf,
  output logic      lf
);
  // ==========================================
  // toggling sources
  localparam int HALF [4] = '{PRI_H, SEC_H, HF_H, LF_H};
  logic [3:0] run;
  logic [3:0] lvl;
  int         cnt [4];
  assign run = {2'h3, sec_en, pri_en};
  assign {lf, hf, sec, pri} = lvl;
  // fixed source rate within the chosen power setting
  // stopped oscillator stays quiet, no free running edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl <= 4'h0;
      for (int i = 0; i < 4; i++) cnt[i] <= 0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!run[i]) begin
          lvl[i] <= 1'b0;
          cnt[i] <= 0;
        end else if (cnt[i] == HALF[i] - 1) begin
          lvl[i] <= ~lvl[i];
          cnt[i] <= 0;
        end else begin
          cnt[i] <= cnt[i] + 1;
        end
      end
    end
  end
endmodule : osc_model
`default_nettype wire

/* File: test_system_clock_source_select.sv */
// self-checking bench for system clock source selection
// assumes osc_model supplies every oscillator level in step with pclk
`timescale 1ns/100ps
`default_nettype none
module test_system_clock_source_select
  import clk_sel_pkg::*;
;
  // ==========================================
  // signals
  localparam int PRI_H = 3;
  localparam int SEC_H = 6;
  localparam int HF_H  = 2;
  localparam int LF_H  = 8;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er;
  logic [3:0]  fosc_cfg;
  logic        sw_en, pri, sec, hf, lf;
  logic        gpio_d, gpio_oe, pin_o, pin_oe;
  logic        pri_en, sec_en, sysclk, busy;
  logic [1:0]  src;
  int          errors, compares, hi_run, per, cko_per;

  system_clock_source_select dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fosc_cfg(fosc_cfg), .primary_sw_enable(sw_en),
    .primary_xtal_clk(pri), .secondary_osc_clk(sec), .internal_high_osc(hf), .internal_low_osc(lf),
    .osc_pin_in(pri), .gpio_out_data(gpio_d), .gpio_out_oe(gpio_oe),
    .osc_pin_out_o(pin_o), .osc_pin_out_oe(pin_oe),
    .primary_osc_en(pri_en), .secondary_osc_en(sec_en),
    .sysclk(sysclk), .sysclk_src(src), .switch_busy(busy)
  );
  osc_model #(.PRI_H(PRI_H), .SEC_H(SEC_H), .HF_H(HF_H), .LF_H(LF_H)) partner (
    .pclk(pclk), .presetn(presetn), .pri_en(pri_en), .sec_en(sec_en),
    .pri(pri), .sec(sec), .hf(hf), .lf(lf)
  );

  // ==========================================
  // tasks
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic hang();
    errors++;
    test_done();
  endtask : hang
  // request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, rd, exp);
  endtask : rchk
  task automatic wait_src(input logic [1:0] e);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(src === e && busy === 1'b0) && n < 4000);
    if (n >= 4000) hang();
  endtask : wait_src
  // cycles between the second and third rising edge
  task automatic measure(input logic w, output int p);
    int   n, r;
    logic prev, cur;
    n = 0;
    r = 0;
    p = 0;
    prev = 1'b1;
    while (r < 3 && n < 3000) begin
      @(posedge pclk);
      cur = w ? pin_o : sysclk;
      if (r == 2) p++;
      if (cur === 1'b1 && prev === 1'b0) r++;
      prev = cur;
      n++;
    end
    if (n >= 3000) hang();
  endtask : measure
  task automatic do_reset(input logic [3:0] f);
    @(posedge pclk);
    presetn  <= 1'b0;
    fosc_cfg <= f;
    repeat (12) @(posedge pclk);
    presetn  <= 1'b1;
  endtask : do_reset

  // ==========================================
  // runt pulse watch, every high phase at least HF_H cycles, the shortest source half period
  always @(posedge pclk) begin
    if (presetn !== 1'b1) hi_run <= 0;
    else if (sysclk === 1'b1) hi_run <= hi_run + 1;
    else begin
      if (hi_run != 0) check("sysclk_high_len", 32'(hi_run >= HF_H), 32'h1);
      hi_run <= 0;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, sw_en, gpio_d, gpio_oe} = 7'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fosc_cfg = FOSC_HS;
    errors = 0;
    compares = 0;
    hi_run = 0;
    do_reset(FOSC_HS);
    rchk("ctrl", OSC_CTRL_OFS, 32'h0000_0038);
    rchk("ctrl2", OSC_CTRL2_OFS, 32'h0000_0004);
    rchk("tune", OSC_TUNE_OFS, 32'h0000_0000);
    rchk("tmr1", TMR1_CTRL_OFS, 32'h0000_0000);
    rchk("status", CLK_STAT_OFS, 32'h0000_0008);
    apb(1'b0, 8'h14, 32'h0000_0000);
    check("unmapped_err", 32'(er), 32'h1);
    check("unmapped_data", rd, 32'h0000_0000);
    apb(1'b1, TMR1_CTRL_OFS, 32'h0000_0008);
    @(negedge pclk);
    check("sec_en", 32'(sec_en), 32'h1);
    rchk("status_sec", CLK_STAT_OFS, 32'h0000_0018);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0031);
    wait_src(SRC_SEC);
    measure(1'b0, per);
    check("sec_period", 32'(per), 32'(2 * SEC_H));
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0002);
    wait_src(SRC_LF);
    measure(1'b0, per);
    check("lf_period", 32'(per), 32'(2 * LF_H));
    apb(1'b1, OSC_TUNE_OFS, 32'h0000_0080);
    wait_src(SRC_HF);
    rchk("hf_status", CLK_STAT_OFS, 32'h0000_001A);
    // odd steps use select 11, even steps 10
    for (int i = 7; i >= 1; i--) begin
      apb(1'b1, OSC_CTRL_OFS, 32'((i << 4) | (i % 2 ? 3 : 2)));
      wait_src(SRC_HF);
      measure(1'b0, per);
      check("hf_period", 32'(per), 32'((2 * HF_H) << (7 - i)));
    end
    apb(1'b1, OSC_CTRL2_OFS, 32'h0000_0000);
    @(negedge pclk);
    check("pri_en_locked", 32'(pri_en), 32'h1);
    @(posedge pclk);
    sw_en <= 1'b1;
    @(negedge pclk);
    check("pri_en_off", 32'(pri_en), 32'h0);
    apb(1'b1, OSC_CTRL2_OFS, 32'h0000_0004);
    @(negedge pclk);
    check("pri_en_on", 32'(pri_en), 32'h1);
    apb(1'b1, OSC_CTRL2_OFS, 32'h0000_0000);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0030);
    @(negedge pclk);
    check("pri_en_sel", 32'(pri_en), 32'h1);
    wait_src(SRC_PRI);
    check("pri_en_run", 32'(pri_en), 32'h1);
    measure(1'b0, per);
    check("pri_period", 32'(per), 32'(2 * PRI_H));
    // rc, ec and internal codes: odd drive clock out, even hand pin two to port logic
    for (int c = 3; c <= 12; c++) begin
      do_reset(4'(c));
      @(posedge pclk);
      gpio_d  <= 1'b1;
      gpio_oe <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("pin2_oe", 32'(pin_oe), 32'h1);
      if (c % 2 == 1) begin
        cko_per = (c > 10) ? CKO_DIV * ((2 * HF_H) << (7 - IFS_RST)) : CKO_DIV * 2 * PRI_H;
        measure(1'b1, per);
        check("clock_output_pin_period", 32'(per), 32'(cko_per));
      end else begin
        check("pin2_io", 32'(pin_o), 32'h1);
        @(posedge pclk);
        gpio_oe <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("pin2_io_off", 32'(pin_oe), 32'h0);
      end
    end
    test_done();
  end
endmodule : test_system_clock_source_select
`default_nettype wire
